/* File: core/pmic_power_sequencer.v */
// Power-on and power-off sequencer with AHB-Lite registers and interrupt
//
// Operation
// [R1] Key low, charger valid, or test starts
// [R2] Buck first, digital supply at 90 percent
// [R3] 65ms reset timer after digital supply good
// [R4] Aux regulators follow own enables once started
// [R5] Aux regulators forced off while core off
// [R6] Host raises hold before key released
// [R7] Core enabled by key OR hold
// [R8] Charger supply starts full sequence automatically
// [R9] No power-down while charger supply valid
// [R10] Test enable high requests startup
// [R11] Second key press pulses buffered key output
// [R12] Host powers down, drops hold last
// [R13] Power-down only with key and hold low; a soft off write also powers down with key or hold high
// [R14] Aux regulators off together with buck
// [R15] Tx and rx discharge pull-downs at shutdown
// [R16] Battery-only key press starts user power-down
// [R17] Key debounced before being used
//
// The AHB-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "power_seq_regs.vh"

module pmic_power_sequencer #(
    parameter [23:0] RESET_CYCLES    = `RESET_CYCLES,
    parameter [23:0] DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
    // AHB-Lite clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // Enable pins from host and button
    input  wire        en_key_n,
    input  wire        en_hold,
    input  wire        en_test,
    input  wire        charger_supply_input,
    input  wire [3:0]  aux_enable,
    // Regulator good indications
    input  wire        buck_good,
    input  wire        digital_supply_good,
    // Regulator enables
    output reg         buck_enable,
    output reg         digital_supply_reg,
    output reg         analog_supply_reg,
    output reg         tcxo_supply_reg,
    output reg         tx_supply_reg,
    output reg         rx_supply_reg,
    output reg         tx_discharge,
    output reg         rx_discharge,
    // Host signalling
    output reg         cpu_reset_n,
    output reg         on_key_n,
    output reg         irq
);

// ==========================================================================
// Sequencer states
// ==========================================================================
localparam [2:0] ST_OFF       = 3'd0;  // Core and aux off
localparam [2:0] ST_BUCK      = 3'd1;  // Buck ramping
localparam [2:0] ST_DIGITAL   = 3'd2;  // Digital supply ramping
localparam [2:0] ST_RESET     = 3'd3;  // Reset timer running
localparam [2:0] ST_RUN       = 3'd4;  // System running

// ==========================================================================
// Input conditioning
// ==========================================================================
wire       key_level;       // Debounced key pin, low when pressed
reg  [1:0] hold_sync;       // Hold enable synchroniser
reg  [1:0] test_sync;       // Test enable synchroniser
reg  [1:0] chg_sync;        // Charger valid synchroniser
reg  [1:0] bgood_sync;      // Buck good synchroniser
reg  [1:0] dgood_sync;      // Digital good synchroniser
reg  [3:0] aux_sync_a;      // Aux enable first stage
reg  [3:0] aux_sync_b;      // Aux enable second stage
reg        key_live;        // Debounced key valid

// [R17] key debounce filter
input_debounce #(
    .STABLE_CYCLES (DEBOUNCE_CYCLES)
) u_key_debounce (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .pin         (en_key_n),
    .reset_level (1'b1),
    .level       (key_level)
);

// Two flops on every asynchronous pin before use
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        hold_sync  <= 2'h0;
        test_sync  <= 2'h0;
        chg_sync   <= 2'h0;
        bgood_sync <= 2'h0;
        dgood_sync <= 2'h0;
        aux_sync_a <= 4'h0;
        aux_sync_b <= 4'h0;
        key_live   <= 1'b0;
    end else begin
        hold_sync  <= {hold_sync[0], en_hold};
        test_sync  <= {test_sync[0], en_test};
        chg_sync   <= {chg_sync[0], charger_supply_input};
        bgood_sync <= {bgood_sync[0], buck_good};
        dgood_sync <= {dgood_sync[0], digital_supply_good};
        aux_sync_a <= aux_enable;
        aux_sync_b <= aux_sync_a;
        key_live   <= 1'b1;
    end
end

// The filter loads its idle level one edge after reset; read before that
// the key would look pressed and start a false power-up
wire key_pressed = key_live & ~key_level;  // Active-high debounced key
wire hold_on     = hold_sync[1];
wire test_on     = test_sync[1];
wire chg_on      = chg_sync[1];

// ==========================================================================
// Registers
// ==========================================================================
reg                   soft_off;     // Software-requested power-down
reg [`IRQ_WIDTH-1:0]  irq_status;   // Sticky events
reg [`IRQ_WIDTH-1:0]  irq_mask;     // Event enables
reg [2:0]             state;        // Sequencer state
reg [2:0]             next_state;   // Next sequencer state
reg [23:0]            timer;        // Reset timer
reg                   key_prev;     // Key level last cycle
reg                   key_armed;    // Key released once since power-up
reg                   on_key_pulse; // One-cycle key event

// Power request: key OR hold, plus charger or test
// [R7] core from key OR hold
wire user_request = key_pressed | hold_on;
// [R1] three startup sources
// [R8] charger starts sequence
// [R10] test enable as request
// [R9] charger blocks power-down
// [R13] down only with key and hold low, or on soft off
wire power_request = (user_request & ~soft_off) | chg_on | test_on;

// ==========================================================================
// Next-state logic
// ==========================================================================
always @* begin
    next_state = state;
    case (state)
        ST_OFF: begin
            if (power_request)
                next_state = ST_BUCK;
        end
        ST_BUCK: begin
            // [R2] digital supply waits for buck
            if (!power_request)
                next_state = ST_OFF;
            else if (bgood_sync[1])
                next_state = ST_DIGITAL;
        end
        ST_DIGITAL: begin
            if (!power_request)
                next_state = ST_OFF;
            else if (dgood_sync[1])
                next_state = ST_RESET;
        end
        ST_RESET: begin
            // [R3] timer expiry releases reset
            if (!power_request)
                next_state = ST_OFF;
            else if (timer >= RESET_CYCLES - 24'h000001)
                next_state = ST_RUN;
        end
        ST_RUN: begin
            // Charger or test holds the request, so no power-down then
            if (!power_request)
                next_state = ST_OFF;
        end
        default: begin
            next_state = ST_OFF;
        end
    endcase
end

// ==========================================================================
// State, timer and key event tracking
// ==========================================================================
// Key must be released once after power-up before a press counts again,
// so the holding press of startup never raises the interrupt.
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        state        <= ST_OFF;
        timer        <= 24'h000000;
        key_prev     <= 1'b0;
        key_armed    <= 1'b0;
        on_key_pulse <= 1'b0;
    end else begin
        state    <= next_state;
        key_prev <= key_pressed;
        // Timer counts only while holding reset
        if (state == ST_RESET && next_state == ST_RESET)
            timer <= timer + 24'h000001;
        else
            timer <= 24'h000000;
        // Arm after release in running state
        if (state != ST_RUN)
            key_armed <= 1'b0;
        else if (!key_pressed)
            key_armed <= 1'b1;
        // [R11] second press pulses on_key
        // [R16] battery-only press starts power-down
        on_key_pulse <= (state == ST_RUN) & key_armed & key_pressed & ~key_prev;
    end
end

// ==========================================================================
// Regulator and host outputs
// ==========================================================================
wire core_on = (state != ST_OFF);
wire aborted = (state == ST_BUCK || state == ST_DIGITAL || state == ST_RESET)
               && next_state == ST_OFF;

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        buck_enable        <= 1'b0;
        digital_supply_reg <= 1'b0;
        analog_supply_reg  <= 1'b0;
        tcxo_supply_reg    <= 1'b0;
        tx_supply_reg      <= 1'b0;
        rx_supply_reg      <= 1'b0;
        tx_discharge       <= 1'b1;
        rx_discharge       <= 1'b1;
        cpu_reset_n        <= 1'b0;
        on_key_n           <= 1'b1;
    end else begin
        // [R2] buck first, digital after buck good
        buck_enable        <= (next_state != ST_OFF);
        digital_supply_reg <= (next_state != ST_OFF) && (next_state != ST_BUCK);
        // [R4] aux follows own enables
        // [R5] aux forced off while core off
        // [R14] aux drop with buck
        analog_supply_reg  <= (next_state != ST_OFF) & aux_sync_b[0];
        tcxo_supply_reg    <= (next_state != ST_OFF) & aux_sync_b[1];
        tx_supply_reg      <= (next_state != ST_OFF) & aux_sync_b[2];
        rx_supply_reg      <= (next_state != ST_OFF) & aux_sync_b[3];
        // [R15] discharge pull-downs when off
        tx_discharge       <= (next_state == ST_OFF) | ~aux_sync_b[2];
        rx_discharge       <= (next_state == ST_OFF) | ~aux_sync_b[3];
        // [R3] reset held until timer expires
        cpu_reset_n        <= (next_state == ST_RUN);
        on_key_n           <= ~on_key_pulse;
    end
end

// ==========================================================================
// AHB-Lite address phase capture
// ==========================================================================
reg       ph_write;   // Pending write
// Reads are answered from the address phase, so no pending read is kept
reg [7:0] ph_addr;    // Pending address

wire ph_take = hsel & hready & htrans[1];

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ph_write  <= 1'b0;
        ph_addr   <= 8'h00;
        hreadyout <= 1'b1;
        hresp     <= 1'b0;
    end else begin
        // Zero wait states, always OKAY
        ph_write  <= ph_take & hwrite;
        if (ph_take)
            ph_addr <= haddr;
        hreadyout <= 1'b1;
        hresp     <= 1'b0;
    end
end

// Read mux decode, unmapped reads zero
function [31:0] read_word;
    input [7:0] addr;
    begin
        case (addr)
            `REG_CTRL:       read_word = {31'h0, soft_off};
            `REG_STATUS:     read_word = {20'h0, aux_sync_b, chg_on, test_on,
                                          hold_on, key_pressed, cpu_reset_n, state};
            `REG_IRQ_STATUS: read_word = {28'h0, irq_status};
            `REG_IRQ_MASK:   read_word = {28'h0, irq_mask};
            `REG_CONFIG:     read_word = {8'h0, RESET_CYCLES};
            default:         read_word = 32'h0000_0000;
        endcase
    end
endfunction

// Read data registered at the address phase so it stands in the data phase
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
        hrdata <= 32'h0000_0000;
    else if (ph_take & ~hwrite)
        hrdata <= read_word(haddr);
end

// ==========================================================================
// Software registers and interrupt
// ==========================================================================
wire [`IRQ_WIDTH-1:0] irq_events = {aborted,
                                    core_on & (next_state == ST_OFF) & ~aborted,
                                    (state == ST_RESET) & (next_state == ST_RUN),
                                    on_key_pulse};
wire [`IRQ_WIDTH-1:0] irq_clear = (ph_write && ph_addr == `REG_IRQ_STATUS) ?
                                  hwdata[`IRQ_WIDTH-1:0] : 4'h0;

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        soft_off   <= 1'b0;
        irq_status <= 4'h0;
        irq_mask   <= `IRQ_MASK_RESET;
        irq        <= 1'b0;
    end else begin
        // Soft off lets host drop key/hold request; charger and test still win
        if (ph_write && ph_addr == `REG_CTRL)
            soft_off <= hwdata[`CTRL_SOFT_OFF];
        else if (state == ST_OFF)
            soft_off <= 1'b0;
        // A mask bit of one lets its event through to irq
        if (ph_write && ph_addr == `REG_IRQ_MASK)
            irq_mask <= hwdata[`IRQ_WIDTH-1:0];
        // Set wins over write-one-to-clear
        irq_status <= (irq_status & ~irq_clear) | irq_events;
        irq        <= |((irq_status & ~irq_clear | irq_events) & irq_mask);
    end
end

endmodule // pmic_power_sequencer

/* File: core/power_seq_regs.vh */
// Register offsets, field positions, reset values and timing counts of the power sequencer
`ifndef POWER_SEQ_REGS_VH
`define POWER_SEQ_REGS_VH

// ==========================================================================
// Register byte offsets
// ==========================================================================
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_IRQ_STATUS  8'h08
`define REG_IRQ_MASK    8'h0c
`define REG_CONFIG      8'h10

// ==========================================================================
// Control fields
// ==========================================================================
`define CTRL_SOFT_OFF   0
`define CTRL_RESET      32'h0000_0000

// ==========================================================================
// Interrupt status and mask fields
// ==========================================================================
`define IRQ_KEY_PRESS   0
`define IRQ_POWER_UP    1
`define IRQ_POWER_DOWN  2
`define IRQ_ABORT       3
`define IRQ_WIDTH       4
`define IRQ_MASK_RESET  4'h0

// ==========================================================================
// Timing (clock 10 MHz, 100 ns)
// ==========================================================================
`define CLK_PERIOD_NS   100
`define RESET_TIME_MS   65
`define RESET_CYCLES    ((`RESET_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define DEBOUNCE_TIME_MS 300
`define DEBOUNCE_CYCLES ((`DEBOUNCE_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define DEBOUNCE_WIDTH  24
`define TIMER_WIDTH     24

`endif

/* File: core/input_debounce.v */
// Two-flop synchroniser followed by a stability counter for one input pin
`timescale 1ns/1ps

module input_debounce #(
    parameter [23:0] STABLE_CYCLES = 24'h000010
) (
    // Clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // Raw pin and filtered level
    input  wire        pin,
    input  wire        reset_level,
    output reg         level
);

// ==========================================================================
// Synchroniser
// ==========================================================================
reg        sync_a;   // First stage, read only by sync_b
reg        sync_b;   // Second stage, safe to use
reg [23:0] count;    // Cycles the new level has held

// Two flops before any logic looks at the pin
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        sync_a <= 1'b0;
        sync_b <= 1'b0;
    end else begin
        sync_a <= pin;
        sync_b <= sync_a;
    end
end

// ==========================================================================
// Stability filter
// ==========================================================================
// Reset constant is zero; the idle level is loaded on the first clock
reg started;
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        started <= 1'b0;
        level   <= 1'b0;
        count   <= 24'h000000;
    end else if (!started) begin
        // Load idle level after release, not under reset
        started <= 1'b1;
        level   <= reset_level;
        count   <= 24'h000000;
    end else if (sync_b == level) begin
        // No change pending
        count <= 24'h000000;
    end else if (count >= STABLE_CYCLES - 24'h000001) begin
        // Held long enough: accept new level
        level <= sync_b;
        count <= 24'h000000;
    end else begin
        count <= count + 24'h000001;
    end
end

endmodule // input_debounce

/* File: test/host_model.sv */
// Regulator feedback and host processor model facing the sequencer
`timescale 1ns/1ps

module host_model (
    // Clock and reset
    input  wire       hclk,
    input  wire       hresetn,
    // Sequencer outputs
    input  wire       buck_enable,
    input  wire       digital_supply_reg,
    input  wire       cpu_reset_n,
    input  wire       on_key_n,
    // Pins the host also watches
    input  wire       en_test,
    input  wire       charger_supply_input,
    // Bench permission to take over the hold
    input  wire       hold_ok,
    // Answers
    output reg        buck_good = 1'h0,
    output reg        digital_supply_good = 1'h0,
    output reg        en_hold = 1'h0
);
    reg [3:0] ramp;   // Buck ramp delay line, slow on purpose
    reg       armed;  // One hold take-over per boot

    // ==========================================================
    // Regulators
    // ==========================================================
    // Buck is slow to reach 90 percent, digital supply is quick
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ramp <= 4'h0;
            buck_good <= 1'h0;
            digital_supply_good <= 1'h0;
        end else begin
            ramp <= {ramp[2:0], buck_enable};
            buck_good <= buck_enable & ramp[3];
            digital_supply_good <= digital_supply_reg;
        end
    end

    // ==========================================================
    // Host processor
    // ==========================================================
    // Re-armed while held in reset so the hold is not raised twice
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_hold <= 1'h0;
            armed <= 1'h1;
        end else begin
            if (!cpu_reset_n) begin
                armed <= 1'h1;
            end
            if (!on_key_n && !en_test && !charger_supply_input) begin
                en_hold <= 1'h0;
            end else if (cpu_reset_n && armed && hold_ok) begin
                en_hold <= 1'h1;
                armed <= 1'h0;
            end
        end
    end
endmodule // host_model

/* File: test/power_seq_assertions.sv */
// Concurrent checks of the sequencer pins
`timescale 1ns/1ps

module power_seq_assertions (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Requests and feedback
    input wire en_test,
    input wire charger_supply_input,
    input wire buck_good,
    // Regulator enables and discharges
    input wire buck_enable,
    input wire digital_supply_reg,
    input wire analog_supply_reg,
    input wire tcxo_supply_reg,
    input wire tx_supply_reg,
    input wire rx_supply_reg,
    input wire tx_discharge,
    input wire rx_discharge,
    // Host signalling
    input wire cpu_reset_n,
    input wire on_key_n
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Any auxiliary regulator on
    wire aux_any = analog_supply_reg | tcxo_supply_reg | tx_supply_reg | rx_supply_reg;

    // ==========================================================
    // Sequencing
    // ==========================================================
    // aux need core
    property p_aux_off; !buck_enable |-> !aux_any; endproperty
    a_aux_off: assert property (p_aux_off) else $error("Aux on with core off");
    property p_dig_rise; $rose(digital_supply_reg) |-> $past(buck_good, 3); endproperty
    a_dig_rise: assert property (p_dig_rise) else $error("Digital before buck good");
    property p_dig_buck; digital_supply_reg |-> buck_enable; endproperty
    a_dig_buck: assert property (p_dig_buck) else $error("Digital without buck");
    property p_rst_dig; cpu_reset_n |-> digital_supply_reg; endproperty
    a_rst_dig: assert property (p_rst_dig) else $error("Reset released early");
    property p_dis_on;
        (tx_supply_reg |-> !tx_discharge) and (rx_supply_reg |-> !rx_discharge);
    endproperty
    a_dis_on: assert property (p_dis_on) else $error("Pull-down on live output");
    property p_dis_off; !buck_enable |-> tx_discharge && rx_discharge; endproperty
    a_dis_off: assert property (p_dis_off) else $error("No pull-down when off");
    property p_key_pulse; !on_key_n |=> on_key_n; endproperty
    a_key_pulse: assert property (p_key_pulse) else $error("Key output too long");
    property p_chg_on; charger_supply_input [*5] |-> buck_enable; endproperty
    a_chg_on: assert property (p_chg_on) else $error("Off with charger valid");
    property p_test_on; en_test [*5] |-> buck_enable; endproperty
    a_test_on: assert property (p_test_on) else $error("Off with test high");
endmodule // power_seq_assertions

/* File: test/tb.sv */
// Self-checking bench of the power sequencer
`timescale 1ns/1ps

module tb;
    localparam int RST_CYC = 20;  // Shortened reset timer
    localparam int BUCK = 0, RST = 1, OKEY = 2, DGOOD = 3, HOLD = 4;
    // Bus, pins and outputs
    logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h0;
    logic [31:0] hwdata = 32'h0, hrdata;
    logic        hreadyout, hresp, irq, cpu_reset_n, on_key_n, en_hold, hold_ok = 1'h0;
    logic        en_key_n = 1'h1, en_test = 1'h0, charger_supply_input = 1'h0;
    logic [3:0]  aux_enable = 4'h0;
    logic        buck_good, digital_supply_good, buck_enable, digital_supply_reg;
    logic        analog_supply_reg, tcxo_supply_reg, tx_supply_reg, rx_supply_reg;
    logic        tx_discharge, rx_discharge;
    int          n_errors = 0, n_checks = 0, cycles = 0;
    logic [31:0] seed = 32'h5;

    pmic_power_sequencer #(.RESET_CYCLES(24'h000014), .DEBOUNCE_CYCLES(24'h000004))
        DUT (.hready(hreadyout), .*);
    host_model u_host (.*);

    // ==========================================================
    // Clock, timeout and helpers
    // ==========================================================
    initial forever #50 hclk = ~hclk;
    // Hang guard, far above the expected run length
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            conclude();
        end
    end
    // Repeatable random source
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function logic sel(input int w);
        case (w)
            BUCK: sel = buck_enable;
            RST: sel = cpu_reset_n;
            OKEY: sel = on_key_n;
            DGOOD: sel = digital_supply_good;
            default: sel = en_hold;
        endcase
    endfunction
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask
    // Bounded wait on one output, then compare it
    task wait_for(input string name, input int w, input logic v);
        int i;
        for (i = 0; i < 3000 && sel(w) !== v; i++) tick(1);
        chk(name, sel(w), v);
    endtask
    // Single AHB-Lite word transfer
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
             output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        rd = hrdata;
    endtask
    // Button press with random contact bounce before it settles low
    task press;
        logic [31:0] r;
        repeat (3) begin
            r = xs();
            @(posedge hclk) en_key_n <= r[0];
        end
        @(posedge hclk) en_key_n <= 1'h0;
    endtask
    task conclude;
        if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    initial begin
        logic [31:0] rd, r;
        int n;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        // Reset values, read-only config, unmapped place
        ahb(1'h0, 8'h0c, 32'h0, rd);
        chk("mask_reset", rd, 32'h0);
        chk("okay", {hreadyout, hresp}, 2'h2);
        ahb(1'h1, 8'h10, 32'h7, rd);
        ahb(1'h0, 8'h10, 32'h0, rd);
        chk("config", rd, RST_CYC);
        ahb(1'h0, 8'h20, 32'h0, rd);
        chk("unmapped", rd, 32'h0);
        // Key start-up with host take-over
        hold_ok <= 1'h1;
        press();
        wait_for("buck_on", BUCK, 1'h1);
        wait_for("dig_good", DGOOD, 1'h1);
        n = 0;
        while (cpu_reset_n !== 1'h1 && n < 200) begin
            tick(1);
            n++;
        end
        chk("reset_time", n >= RST_CYC && n <= RST_CYC + 6, 1'h1);
        wait_for("hold", HOLD, 1'h1);
        @(posedge hclk) en_key_n <= 1'h1;
        tick(30);
        chk("stay_on", buck_enable, 1'h1);
        repeat (3) begin
            r = xs();
            @(posedge hclk) aux_enable <= r[3:0];
            tick(5);
            chk("aux", {rx_supply_reg, tx_supply_reg, tcxo_supply_reg, analog_supply_reg}, r[3:0]);
        end
        @(posedge hclk) aux_enable <= 4'hf;
        // Interrupt raised, masked, cleared
        ahb(1'h0, 8'h08, 32'h0, rd);
        chk("up_event", rd[1], 1'h1);
        chk("irq_masked", irq, 1'h0);
        ahb(1'h1, 8'h0c, 32'hf, rd);
        tick(3);
        chk("irq_on", irq, |rd[3:0]);
        ahb(1'h1, 8'h08, 32'hf, rd);
        ahb(1'h0, 8'h08, 32'h0, rd);
        chk("irq_clear", rd, 32'h0);
        chk("irq_off", irq, 1'h0);
        ahb(1'h1, 8'h0c, 32'h0, rd);
        // Second press, host powers down
        press();
        wait_for("key_irq", OKEY, 1'h0);
        wait_for("hold_drop", HOLD, 1'h0);
        @(posedge hclk) en_key_n <= 1'h1;
        wait_for("buck_off", BUCK, 1'h0);
        chk("aux_off", {rx_supply_reg, tx_supply_reg, tcxo_supply_reg, analog_supply_reg}, 4'h0);
        chk("discharge", {tx_discharge, rx_discharge}, 2'h3);
        // Key released before the host takes over
        hold_ok <= 1'h0;
        press();
        wait_for("abort_on", BUCK, 1'h1);
        @(posedge hclk) en_key_n <= 1'h1;
        wait_for("abort_off", BUCK, 1'h0);
        ahb(1'h0, 8'h08, 32'h0, rd);
        chk("events", rd[3:0], 4'hd);
        // Charger start and refusal to power down
        @(posedge hclk) charger_supply_input <= 1'h1;
        wait_for("chg_run", RST, 1'h1);
        ahb(1'h1, 8'h00, 32'h1, rd);
        tick(50);
        chk("chg_stay", buck_enable, 1'h1);
        @(posedge hclk) charger_supply_input <= 1'h0;
        wait_for("chg_off", BUCK, 1'h0);
        ahb(1'h0, 8'h00, 32'h0, rd);
        chk("soft_clear", rd, 32'h0);
        // Short glitch is filtered, then test enable
        @(posedge hclk) en_key_n <= 1'h0;
        @(posedge hclk);
        @(posedge hclk) en_key_n <= 1'h1;
        tick(20);
        chk("glitch", buck_enable, 1'h0);
        @(posedge hclk) en_test <= 1'h1;
        wait_for("test_on", BUCK, 1'h1);
        @(posedge hclk) en_test <= 1'h0;
        wait_for("test_off", BUCK, 1'h0);
        conclude();
    end
endmodule // tb

bind pmic_power_sequencer power_seq_assertions u_chk (.*);
